// ### design/psc_cfg.svh
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH
// Overview of operation
// (R1) mode select acts only while standby set
// (R2) unlock register write-only, byte wide, reads undefined
// (R3) control write only right after unlock write
// (R4) unlock accepts any data value
// (R5) no interrupt acknowledge on unlock store
// (R6) bit5 set blocks nmi wake from standby
// (R7) bit4 set blocks maskable wake from standby
// (R8) bit1 enters standby, self-clears on release
// (R9) software writes zero to bits 7,6
// (R10) set wake disables before standby request
// (R11) software runs five nops after entry
// (R12) software finishes dma before entry sequence
// (R13) wake disables ignored for halt release
// (R14) masked interrupts never release standby
// (R15) halt stops only cpu clock
// (R16) halt keeps state, bus pins, clock output
// (R17) halt ends on nmi, unmasked irq, reset
// (R18) lower priority in isr: wake, keep pending
// (R19) higher priority or nmi: wake, acknowledge
// (R20) after wake: branch rules by source, ei
// (R21) reset pin release equals system reset
// (R22) idle keeps osc and pll, gates clocks
// (R23) stop halts osc, pll and clocks
// (R24) mode select field picks idle or stop
// (R25) unlock armed for exactly the next store

// register addresses
`define PSC_ADDR_CTRL   32'hFFFFF1FE
`define PSC_ADDR_MODE   32'hFFFFF1FC
`define PSC_ADDR_UNLOCK 32'hFFFFF1FA

// control register fields and reset value
`define PSC_BIT_NMI_DIS 5
`define PSC_BIT_IRQ_DIS 4
`define PSC_BIT_STBY    1
`define PSC_CTRL_RST    8'h00
`define PSC_CTRL_WMASK  8'h32

// mode select register fields and reset value
`define PSC_BIT_STOP_SEL 0
`define PSC_MODE_RST     8'h00
`define PSC_MODE_WMASK   8'h01

// read value of the write-only unlock register
`define PSC_UNLOCK_RD 8'h00
`endif

// ### design/psc_pkg.sv
package psc_pkg;

   // one-hot power states
   typedef enum logic [3:0] {
      PSC_RUN  = 4'h1,
      PSC_HALT = 4'h2,
      PSC_IDLE = 4'h4,
      PSC_STOP = 4'h8
   } psc_mode_t;

   // state of the main controller
   typedef struct packed {
      psc_mode_t  mode;
      logic [7:0] ctrl;
      logic [7:0] msel;
      logic       unlock;
      logic [7:0] rdata;
      logic       wake;
      logic       branch;
      logic       ack;
      logic       pend;
   } psc_state_t;

   // state of a pin synchroniser
   typedef struct packed {
      logic [2:0] ff;
      logic       lvl;
   } psc_sync_t;

endpackage

// ### design/psc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module psc_sync
   import psc_pkg::*;
(
   // clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_arst_n,
   // pin and filtered level
   input  wire logic i_pin,
   input  wire logic i_rst_val,
   output logic      o_lvl
);
   psc_sync_t s_q;
   psc_sync_t s_d;

   // stage 0 feeds only stage 1; level moves when stages 1 and 2 agree
   // the pin is stored relative to its idle level, so the all-zero reset
   // state already matches an idle pin and no false event follows reset
   always_comb begin
      s_d    = s_q;
      s_d.ff = {s_q.ff[1:0], i_pin ^ i_rst_val};
      if (s_q.ff[1] == s_q.ff[2]) begin
         s_d.lvl = s_q.ff[2];
      end
   end

   // reset branch holds constants only; the idle level is folded in above
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_lvl = s_q.lvl;
endmodule // psc_sync
`default_nettype wire

// ### design/psc_wake.sv
`timescale 1ns/100ps
`default_nettype none
module psc_wake
   import psc_pkg::*;
(
   // current power state and wake disables
   input  wire psc_mode_t i_mode,
   input  wire logic      i_nmi_dis,
   input  wire logic      i_irq_dis,
   // wake sources
   input  wire logic      i_nmi_edge,
   input  wire logic      i_irq_req,
   input  wire logic      i_irq_masked,
   // result
   output logic           o_wake,
   output logic           o_by_nmi
);
   logic unmasked;
   logic stby;

   // masked requests never count as wake sources
   assign unmasked = i_irq_req & ~i_irq_masked; // (R14)
   assign stby     = (i_mode == PSC_IDLE) | (i_mode == PSC_STOP);

   // disables only gate release from idle and stop
   always_comb begin
      o_wake   = 1'b0;
      o_by_nmi = 1'b0;
      case (i_mode)
         PSC_HALT: begin
            o_wake   = i_nmi_edge | unmasked; // (R13) (R17)
            o_by_nmi = i_nmi_edge;
         end
         PSC_IDLE, PSC_STOP: begin
            o_wake   = (i_nmi_edge & ~i_nmi_dis & stby) // (R6)
                     | (unmasked & ~i_irq_dis & stby);  // (R7)
            o_by_nmi = i_nmi_edge & ~i_nmi_dis;
         end
         default: begin
            o_wake   = 1'b0;
            o_by_nmi = 1'b0;
         end
      endcase
   end
endmodule // psc_wake
`default_nettype wire

// ### design/psc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "psc_cfg.svh"
module psc_ctrl
   import psc_pkg::*;
#(
   parameter int ADDR_W = 32
)
(
   // clock and reset
   input  wire logic              i_ref_clk,
   input  wire logic              i_arst_n,
   // cpu store and load port
   input  wire logic              i_wr,
   input  wire logic              i_wr_byte,
   input  wire logic              i_rd,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [7:0]        i_wdata,
   output logic [7:0]             o_rdata,
   // cpu instruction events
   input  wire logic              i_halt_insn,
   input  wire logic              i_int_enabled,
   // interrupt controller
   input  wire logic              i_nmi_pin,
   input  wire logic              i_irq_req,
   input  wire logic              i_irq_masked,
   input  wire logic              i_in_isr,
   input  wire logic              i_pri_higher,
   output logic                   o_ack_inhibit,
   output logic                   o_wake,
   output logic                   o_wake_ack,
   output logic                   o_wake_pend,
   output logic                   o_wake_branch,
   // reset pin
   input  wire logic              i_rst_pin_n,
   output logic                   o_sys_rst_req,
   // clock generator and pin enables
   output logic                   o_cpu_clk_en,
   output logic                   o_sys_clk_en,
   output logic                   o_osc_en,
   output logic                   o_pll_en,
   output logic                   o_clock_output_pin_en,
   output logic                   o_bus_pins_en,
   output logic                   o_standby
);

   // the decode compares against full 32-bit addresses
   if (ADDR_W != 32) begin : g_chk
      $error("psc_ctrl: ADDR_W must be 32");
   end

   psc_state_t s_q;
   psc_state_t s_d;

   logic nmi_lvl;
   logic nmi_lvl_q;
   logic nmi_edge;
   logic rst_pin;
   logic wk;
   logic wk_nmi;
   logic hit_ctrl;
   logic hit_mode;
   logic hit_unlock;

   // address compare shared by store and load decode
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [31:0]       r);
      hit = (a == r);
   endfunction

   // merge written bits into a register through its write mask
   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] wd,
                                        input logic [7:0] m);
      merge = (old & ~m) | (wd & m);
   endfunction

   assign hit_ctrl   = hit(i_addr, `PSC_ADDR_CTRL);
   assign hit_mode   = hit(i_addr, `PSC_ADDR_MODE);
   assign hit_unlock = hit(i_addr, `PSC_ADDR_UNLOCK);

   // nmi pin filtered over three flops
   psc_sync u_nmi_sync (
      .i_ref_clk (i_ref_clk),
      .i_arst_n  (i_arst_n),
      .i_pin     (i_nmi_pin),
      .i_rst_val (1'b0),
      .o_lvl     (nmi_lvl)
   );

   // reset pin filtered; inverted so the idle level reads low
   psc_sync u_rst_sync (
      .i_ref_clk (i_ref_clk),
      .i_arst_n  (i_arst_n),
      .i_pin     (i_rst_pin_n),
      .i_rst_val (1'b1),
      .o_lvl     (rst_pin)
   );

   // rising edge of the filtered nmi level is the valid edge
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         nmi_lvl_q <= 1'b0;
      end else begin
         nmi_lvl_q <= nmi_lvl;
      end
   end
   assign nmi_edge = nmi_lvl & ~nmi_lvl_q;

   // wake decision for the present power state
   psc_wake u_wake (
      .i_mode       (s_q.mode),
      .i_nmi_dis    (s_q.ctrl[`PSC_BIT_NMI_DIS]),
      .i_irq_dis    (s_q.ctrl[`PSC_BIT_IRQ_DIS]),
      .i_nmi_edge   (nmi_edge),
      .i_irq_req    (i_irq_req),
      .i_irq_masked (i_irq_masked),
      .o_wake       (wk),
      .o_by_nmi     (wk_nmi)
   );

   // next-state logic
   always_comb begin
      s_d        = s_q;
      s_d.wake   = 1'b0;
      s_d.ack    = 1'b0;
      s_d.pend   = 1'b0;
      s_d.branch = 1'b0;

      // every store consumes the unlock, whatever its target
      if (i_wr) begin
         s_d.unlock = 1'b0; // (R25)
      end

      // unlock on any byte store to the unlock address, data ignored
      if (i_wr && i_wr_byte && hit_unlock) begin
         s_d.unlock = 1'b1; // (R2) (R4)
      end

      // mode select is a plain register
      if (i_wr && hit_mode && (s_q.mode == PSC_RUN)) begin
         s_d.msel = merge(s_q.msel, i_wdata, `PSC_MODE_WMASK); // (R24)
      end

      // control writes land only when the previous store unlocked
      if (i_wr && hit_ctrl && s_q.unlock && (s_q.mode == PSC_RUN)) begin
         s_d.ctrl = merge(s_q.ctrl, i_wdata, `PSC_CTRL_WMASK); // (R3)
      end

      // load data; the unlock register reads a fixed filler
      s_d.rdata = 8'h00;
      if (i_rd) begin
         if (hit_ctrl) begin
            s_d.rdata = s_q.ctrl; // (R8)
         end else if (hit_mode) begin
            s_d.rdata = s_q.msel;
         end else if (hit_unlock) begin
            s_d.rdata = `PSC_UNLOCK_RD; // (R2)
         end else begin
            s_d.rdata = 8'h00;
         end
      end

      // power state machine
      case (s_q.mode)
         PSC_RUN: begin
            if (s_d.ctrl[`PSC_BIT_STBY]) begin
               // mode select takes effect only with the request set
               if (s_q.msel[`PSC_BIT_STOP_SEL]) begin
                  s_d.mode = PSC_STOP; // (R1) (R8) (R24)
               end else begin
                  s_d.mode = PSC_IDLE; // (R1) (R8) (R24)
               end
            end else if (i_halt_insn) begin
               s_d.mode = PSC_HALT; // (R15)
            end
         end
         PSC_HALT, PSC_IDLE, PSC_STOP: begin
            if (wk) begin
               s_d.mode                 = PSC_RUN;
               s_d.ctrl[`PSC_BIT_STBY]  = 1'b0; // (R8)
               s_d.wake                 = 1'b1; // (R17)
               // in a handler only a higher request or nmi is taken
               s_d.ack    = wk_nmi | ~i_in_isr | i_pri_higher; // (R18) (R19)
               s_d.pend   = ~(wk_nmi | ~i_in_isr | i_pri_higher); // (R18)
               s_d.branch = wk_nmi
                          | (i_int_enabled & (~i_in_isr | i_pri_higher)); // (R20)
            end
         end
         default: begin
            s_d.mode = PSC_RUN;
         end
      endcase

      // reset pin acts as a full system reset of this block
      if (rst_pin) begin
         s_d.mode   = PSC_RUN; // (R21)
         s_d.ctrl   = `PSC_CTRL_RST;
         s_d.msel   = `PSC_MODE_RST;
         s_d.unlock = 1'b0;
         s_d.wake   = 1'b0;
         s_d.ack    = 1'b0;
         s_d.pend   = 1'b0;
         s_d.branch = 1'b0;
      end
   end

   // state register
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_q.mode   <= PSC_RUN;
         s_q.ctrl   <= `PSC_CTRL_RST;
         s_q.msel   <= `PSC_MODE_RST;
         s_q.unlock <= 1'b0;
         s_q.rdata  <= 8'h00;
         s_q.wake   <= 1'b0;
         s_q.branch <= 1'b0;
         s_q.ack    <= 1'b0;
         s_q.pend   <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // keep the unlock store and the protected store together
   assign o_ack_inhibit = (i_wr & hit_unlock) | s_q.unlock; // (R5)

   // registered answers
   assign o_rdata       = s_q.rdata;
   assign o_wake        = s_q.wake;
   assign o_wake_ack    = s_q.ack;
   assign o_wake_pend   = s_q.pend;
   assign o_wake_branch = s_q.branch;
   assign o_sys_rst_req = rst_pin; // (R21)
   assign o_standby     = s_q.ctrl[`PSC_BIT_STBY];

   // clock gating per power state; halt keeps everything but the cpu
   assign o_cpu_clk_en  = (s_q.mode == PSC_RUN); // (R15)
   assign o_sys_clk_en  = (s_q.mode == PSC_RUN) | (s_q.mode == PSC_HALT); // (R22)
   assign o_osc_en      = (s_q.mode != PSC_STOP); // (R23)
   assign o_pll_en      = (s_q.mode != PSC_STOP); // (R22) (R23)
   assign o_clock_output_pin_en   = (s_q.mode == PSC_RUN) | (s_q.mode == PSC_HALT); // (R16)
   assign o_bus_pins_en = (s_q.mode == PSC_RUN) | (s_q.mode == PSC_HALT); // (R16)

endmodule // psc_ctrl
`default_nettype wire

// ### verif/psc_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "psc_cfg.svh"
module psc_ctrl_sva (
   // clock, reset and store port
   input wire logic        i_ref_clk,
   input wire logic        i_arst_n,
   input wire logic        i_wr,
   input wire logic        i_wr_byte,
   input wire logic        i_rd,
   input wire logic [31:0] i_addr,
   input wire logic [7:0]  i_wdata,
   input wire logic [7:0]  o_rdata,
   // wake sources
   input wire logic        i_halt_insn,
   input wire logic        i_nmi_pin,
   input wire logic        i_irq_req,
   input wire logic        i_irq_masked,
   input wire logic        i_in_isr,
   input wire logic        i_pri_higher,
   input wire logic        i_rst_pin_n,
   // results
   input wire logic        o_ack_inhibit,
   input wire logic        o_wake,
   input wire logic        o_wake_ack,
   input wire logic        o_wake_pend,
   input wire logic        o_sys_rst_req,
   input wire logic        o_cpu_clk_en,
   input wire logic        o_sys_clk_en,
   input wire logic        o_osc_en,
   input wire logic        o_standby
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);
   // unlock store, a quiet nmi pin and a halted core with an isr request
   sequence s_unlock;
      i_wr && i_wr_byte && i_addr == `PSC_ADDR_UNLOCK;
   endsequence
   sequence s_quiet;
      !i_nmi_pin [*6];
   endsequence
   sequence s_halted;
      !o_cpu_clk_en && o_sys_clk_en && i_irq_req && !i_irq_masked && i_in_isr;
   endsequence
   property p_inhibit;
      s_unlock |-> o_ack_inhibit;
   endproperty
   property p_enter;
      o_cpu_clk_en && !o_standby ##0 s_unlock ##1
         (i_wr && i_wr_byte && i_addr == `PSC_ADDR_CTRL && i_wdata[1])
         |=> o_standby && !o_cpu_clk_en && !o_sys_clk_en;
   endproperty
   property p_lock;
      !o_standby && !o_ack_inhibit && i_wr && i_addr == `PSC_ADDR_CTRL |=> !o_standby;
   endproperty
   property p_rd_unlock;
      i_rd && i_addr == `PSC_ADDR_UNLOCK |=> o_rdata == `PSC_UNLOCK_RD;
   endproperty
   property p_gated;
      o_standby |-> !o_cpu_clk_en && !o_sys_clk_en;
   endproperty
   property p_halt;
      o_cpu_clk_en && !o_standby && i_halt_insn && !o_sys_rst_req
         |=> !o_cpu_clk_en && o_sys_clk_en && o_osc_en;
   endproperty
   property p_wake_clr;
      o_wake |-> !o_standby && o_cpu_clk_en;
   endproperty
   property p_pend;
      s_quiet ##0 s_halted ##0 !i_pri_higher |=> o_wake && o_wake_pend && !o_wake_ack;
   endproperty
   property p_hi;
      s_quiet ##0 s_halted ##0 i_pri_higher |=> o_wake && o_wake_ack && !o_wake_pend;
   endproperty
   property p_rst;
      !i_rst_pin_n [*5] |-> o_sys_rst_req;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("no inhibit on unlock");
   a_enter: assert property (p_enter) else $error("standby not entered");
   a_lock: assert property (p_lock) else $error("unguarded store took");
   a_rd_unlock: assert property (p_rd_unlock) else $error("unlock read");
   a_gated: assert property (p_gated) else $error("clocks run in standby");
   a_halt: assert property (p_halt) else $error("halt clocks wrong");
   a_wake_clr: assert property (p_wake_clr) else $error("standby kept on wake");
   a_pend: assert property (p_pend) else $error("low request not held");
   a_hi: assert property (p_hi) else $error("high request not taken");
   a_rst: assert property (p_rst) else $error("reset pin ignored");
endmodule // psc_ctrl_sva
`default_nettype wire

// ### verif/psc_irq_model.sv
`timescale 1ns/100ps
`default_nettype none
module psc_irq_model (
   // clock and commands
   input  wire logic i_ref_clk,
   input  wire logic i_fire,
   input  wire logic i_isr,
   input  wire logic i_hi,
   input  wire logic i_wake,
   // request lines
   output var logic  o_req,
   output var logic  o_in_isr,
   output var logic  o_hi
);
   initial {o_req, o_in_isr, o_hi} = 3'h0;
   // request stands until the core wakes; pending ones are dropped too
   always @(posedge i_ref_clk) begin
      if (i_wake) begin
         o_req <= 1'h0;
      end else if (i_fire) begin
         o_req    <= 1'h1;
         o_in_isr <= i_isr;
         o_hi     <= i_hi;
      end
   end
endmodule // psc_irq_model
`default_nettype wire

// ### verif/test_power_save_controller.sv
`timescale 1ns/100ps
`default_nettype none
`include "psc_cfg.svh"
module test_power_save_controller;
   import psc_pkg::*;
   localparam logic [31:0] a_ct = `PSC_ADDR_CTRL;
   localparam logic [31:0] a_md = `PSC_ADDR_MODE;
   localparam logic [31:0] a_ul = `PSC_ADDR_UNLOCK;
   logic clk = 0, rst_n = 0, wr = 0, wb = 1, rd = 0, rdd = 0, halt = 0, ei = 0, nmi = 0;
   logic msk = 0, rpin = 1, fire = 0, isr = 0, hi = 0, req, in_isr, phi, inh, wk, wack, wpend;
   logic wbr, srst, cpu, sys, osc, pll, cko, bus, stby;
   logic [31:0] adr = 0;
   logic [7:0]  wd = 0, rdat;
   logic [3:0]  qw[$];
   logic [7:0]  qr[$];
   int n_mismatch = 0, tests_run = 0, seed = 82, i;
   psc_ctrl #(.ADDR_W(32)) DUT (.i_ref_clk(clk), .i_arst_n(rst_n), .i_wr(wr), .i_wr_byte(wb),
      .i_rd(rd), .i_addr(adr), .i_wdata(wd), .o_rdata(rdat), .i_halt_insn(halt),
      .i_int_enabled(ei), .i_nmi_pin(nmi), .i_irq_req(req), .i_irq_masked(msk),
      .i_in_isr(in_isr), .i_pri_higher(phi), .o_ack_inhibit(inh), .o_wake(wk),
      .o_wake_ack(wack), .o_wake_pend(wpend), .o_wake_branch(wbr), .i_rst_pin_n(rpin),
      .o_sys_rst_req(srst), .o_cpu_clk_en(cpu), .o_sys_clk_en(sys), .o_osc_en(osc),
      .o_pll_en(pll), .o_clock_output_pin_en(cko), .o_bus_pins_en(bus), .o_standby(stby));
   psc_irq_model u_irq (.i_ref_clk(clk), .i_fire(fire), .i_isr(isr), .i_hi(hi), .i_wake(wk),
      .o_req(req), .o_in_isr(in_isr), .o_hi(phi));
   // free-running reference clock
   always #12.5 clk = ~clk;
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("n_mismatch=%0d tests_run=%0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // store leaves the strobe up so that two stores can run back to back
   task automatic st(input logic [31:0] a, input logic [7:0] d, input logic b = 1'h1);
      wr = 1'h1;
      adr = a;
      wd = d;
      wb = b;
      @(negedge clk);
   endtask
   task automatic ld(input logic [31:0] a, input logic [7:0] e);
      wr = 1'h0;
      rd = 1'h1;
      adr = a;
      qr.push_back(e);
      @(negedge clk);
      rd = 1'h0;
      @(negedge clk);
   endtask
   task automatic quiet(input int n);
      wr = 1'h0;
      repeat (n) begin
         @(negedge clk);
         cmp({7'h0, wk}, 8'h00);
      end
   endtask
   // bounded wait for the release pulse
   task automatic ww;
      for (int k = 0; k < 20 && wk !== 1'h1; k++) @(negedge clk);
      if (wk !== 1'h1) begin
         n_mismatch++;
         report_and_stop;
      end
      @(negedge clk);
   endtask
   // watcher: each load answer or wake pulse is matched with the oldest note
   // wake notes hold {wake, acknowledge, pending, branch}
   always @(posedge clk) rdd <= rd;
   always @(negedge clk) begin
      if (rdd) cmp(rdat, qr.pop_front());
      if (wk === 1'h1) begin
         if (qw.size() == 0) cmp(8'hFF, 8'h00);
         else cmp({4'h0, wk, wack, wpend, wbr}, {4'h0, qw.pop_front()});
      end
   end
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'h1;
      ld(a_ct, 8'h00); ld(a_md, 8'h00); ld(a_ul, 8'h00); ld(32'hFFFFF1F0, 8'h00);
      // guarded store alone, after a word unlock, and after a foreign store
      st(a_ct, 8'h30); st(a_ul, 8'($random(seed)), 1'h0); st(a_ct, 8'h30);
      st(a_ul, 8'($random(seed))); st(a_md, 8'h00); st(a_ct, 8'h30); ld(a_ct, 8'h00);
      cmp({7'h0, inh}, 8'h00);
      // disables first, standby later, any unlock data; bits 7,6 kept zero
      st(a_ul, 8'($random(seed)));
      cmp({7'h0, inh}, 8'h01);
      st(a_ct, 8'h30); ld(a_ct, 8'h30);
      st(a_ul, 8'($random(seed))); st(a_ct, 8'h32);
      // drop the strobe at once: an idle core issues no further store
      wr = 1'h0;
      cmp({4'h0, cpu, sys, osc, pll}, 8'h03);
      nmi = 1'h1;
      isr = 1'h0;
      fire = 1'h1;
      quiet(1);
      fire = 1'h0;
      quiet(8);
      nmi = 1'h0;
      msk = 1'h1;
      rpin = 1'h0;
      repeat (6) @(negedge clk);
      cmp({6'h0, srst, stby}, 8'h02);
      rpin = 1'h1;
      repeat (6) @(negedge clk);
      ld(a_ct, 8'h00);
      st(a_md, 8'h01); ld(a_md, 8'h01);
      cmp({4'h0, cpu, sys, osc, pll}, 8'h0F);
      st(a_ul, 8'($random(seed))); st(a_ct, 8'h02);
      wr = 1'h0;
      cmp({4'h0, cpu, sys, osc, pll}, 8'h00);
      quiet(6);
      ei = 1'($random(seed));
      qw.push_back({3'h6, ei});
      msk = 1'h0;
      ww;
      ld(a_ct, 8'h00);
      st(a_ul, 8'h00); st(a_ct, 8'h30); wr = 1'h0;
      // halt with disables set; nmi round sees isr and higher left from round 3
      for (i = 0; i < 5; i++) begin
         ei = 1'($random(seed));
         isr = i[0];
         hi = i[1];
         halt = 1'h1;
         @(negedge clk);
         halt = 1'h0;
         @(negedge clk);
         cmp({3'h0, cpu, sys, osc, cko, bus}, 8'h0F);
         if (i == 4) begin
            qw.push_back(4'hD);
            nmi = 1'h1;
         end else begin
            qw.push_back({1'h1, ~isr | hi, isr & ~hi, ei & (~isr | hi)});
            fire = 1'h1;
            @(negedge clk);
            fire = 1'h0;
         end
         ww;
         nmi = 1'h0;
      end
      repeat (4) @(negedge clk);
      cmp(8'(qw.size() + qr.size()), 8'h00);
      report_and_stop;
   end
endmodule // test_power_save_controller
bind psc_ctrl psc_ctrl_sva u_sva (.*);
`default_nettype wire
